/* File: pkg/tcm_pkg.sv */
// Register map, field layout and filter decoding shared by the channel mode block.
package tcm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register byte addresses.
  localparam logic [7:0] ADDR_MODE_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CMP_VALUE   = 8'h04;
  localparam logic [7:0] ADDR_CHAN_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_STATUS      = 8'h0c;
  localparam logic [7:0] ADDR_CMP_ACTIVE  = 8'h10;
  localparam logic [7:0] ADDR_CH1_CAPTURE = 8'h14;
  localparam logic [7:0] ADDR_CH2_CAPTURE = 8'h18;

  // Reset values.
  localparam logic [15:0] MODE_CTRL_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET       = 16'h0000;
  localparam logic [1:0]  CHAN_CTRL_RESET = 2'h0;

  // Field positions of the mode control register, plus the on bits of the channel control register; channel 2 sits CH_STRIDE bits above channel 1.
  localparam int CH_STRIDE       = 8;
  localparam int DIR_LSB         = 0;
  localparam int PRESCALE_LSB    = 2;
  localparam int FILTER_LSB      = 4;
  localparam int FAST_BIT        = 2;
  localparam int PRELOAD_BIT     = 3;
  localparam int OUT_MODE_LSB    = 4;
  localparam int CH1_ON_BIT      = 0;
  localparam int CH2_ON_BIT      = 1;

  // Direction codes.
  localparam logic [1:0] DIR_OUTPUT    = 2'h0;
  localparam logic [1:0] DIR_OWN_PIN   = 2'h1;
  localparam logic [1:0] DIR_OTHER_PIN = 2'h2;
  localparam logic [1:0] DIR_TRIGGER   = 2'h3;

  // Output modes that matter here.
  localparam logic [2:0] OUT_PWM_A = 3'h6;
  localparam logic [2:0] OUT_PWM_B = 3'h7;

  // Consecutive samples needed per filter setting.
  function automatic logic [3:0] tcm_filter_count(input logic [3:0] s);
    logic [3:0] n;
    n = 4'h1;
    unique case (s)
      4'h0: n = 4'h1;
      4'h1: n = 4'h2;
      4'h2: n = 4'h4;
      4'h3, 4'h5, 4'h7, 4'h9, 4'hc, 4'hf: n = 4'h8;
      4'h4, 4'h6, 4'h8, 4'hb, 4'he: n = 4'h6;
      4'ha, 4'hd: n = 4'h5;
    endcase
    return n;
  endfunction : tcm_filter_count

  // Log2 of the sample base clock divider per filter setting.
  function automatic logic [2:0] tcm_filter_div_log(input logic [3:0] s);
    logic [2:0] d;
    d = 3'h0;
    if (s >= 4'hd) d = 3'h5;
    else if (s >= 4'ha) d = 3'h4;
    else if (s >= 4'h8) d = 3'h3;
    else if (s >= 4'h6) d = 3'h2;
    else if (s >= 4'h4) d = 3'h1;
    return d;
  endfunction : tcm_filter_div_log

  // Settings 1 to 3 sample on every internal timer clock.
  function automatic logic tcm_filter_on_int(input logic [3:0] s);
    return (s >= 4'h1) && (s <= 4'h3);
  endfunction : tcm_filter_on_int

endpackage : tcm_pkg

/* File: rtl/tcm_input_filter.sv */
// Digital input filter for one channel pin.
`timescale 1ns/1ns
module tcm_input_filter (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       sample_tick,
  input  wire logic [3:0] setting,
  // Data
  input  wire logic       pin,
  output logic            filt
);
  import tcm_pkg::*;

  logic [4:0] div_cnt;
  logic [3:0] run_cnt;

  wire [3:0] n_req    = tcm_filter_count(setting);
  wire [2:0] div_log  = tcm_filter_div_log(setting);
  wire       use_int  = tcm_filter_on_int(setting);
  wire [4:0] div_last = 5'((6'h01 << div_log) - 6'h01);
  wire       div_wrap = div_cnt >= div_last;
  wire       sample   = use_int | (sample_tick & div_wrap);
  wire [3:0] next_run = run_cnt + 4'h1;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt <= 5'h00;
      run_cnt <= 4'h0;
      filt    <= 1'b0;
    end else begin
      if (sample_tick) div_cnt <= div_wrap ? 5'h00 : div_cnt + 5'h01;
      if (sample) begin
        if (pin == filt) begin
          run_cnt <= 4'h0;
        end else if (next_run >= n_req) begin
          filt    <= pin;
          run_cnt <= 4'h0;
        end else begin
          run_cnt <= next_run;
        end
      end
    end
  end

  sequence s_two_same;
    ($past(pin, 1) == filt) && ($past(pin, 2) == filt);
  endsequence

  property p_filter_needs_run;
    @(posedge clk) disable iff (rst)
      (use_int && $past(use_int) && $past(use_int, 2) && $changed(filt)) |-> s_two_same;
  endproperty
  a_filter_needs_run: assert property (p_filter_needs_run) else $error("filter passed a short pulse");

endmodule : tcm_input_filter

/* File: rtl/tcm_capture_prescale.sv */
// Capture prescaler counting active edges of one channel.
`timescale 1ns/1ns
module tcm_capture_prescale (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       chan_on,
  input  wire logic [1:0] prescale,
  // Events
  input  wire logic       edge_in,
  output logic            capture
);
  import tcm_pkg::*;

  logic [2:0] edge_cnt;

  wire [2:0] mask = 3'((4'h1 << prescale) - 4'h1);
  wire       due  = (edge_cnt & mask) == mask;

  always_ff @(posedge clk) begin
    if (rst || !chan_on) begin
      edge_cnt <= 3'h0;
      capture  <= 1'b0;
    end else begin
      capture <= edge_in & due;
      if (edge_in) edge_cnt <= edge_cnt + 3'h1;
    end
  end

  property p_clear_when_off;
    @(posedge clk) disable iff (rst) !chan_on |=> (edge_cnt == 3'h0) && !capture;
  endproperty
  a_clear_when_off: assert property (p_clear_when_off) else $error("prescaler not cleared");

  property p_every_edge;
    @(posedge clk) disable iff (rst) (chan_on && prescale == 2'h0 && edge_in) |=> capture;
  endproperty
  a_every_edge: assert property (p_every_edge) else $error("capture missing at divide by one");

endmodule : tcm_capture_prescale

/* File: rtl/tcm_top.sv */
// Channel mode configuration for timer channels 1 and 2: preload and fast output on channel 1 only, input routing on both.
`timescale 1ns/1ns

module tcm_top (
  // Clock and reset
  input  wire logic                       SYS_CLK,
  input  wire logic                       RST,
  // Register port
  input  wire logic [tcm_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [tcm_pkg::DATA_W-1:0] REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output logic      [tcm_pkg::DATA_W-1:0] REG_RDATA,
  // Counter and trigger
  input  wire logic [tcm_pkg::DATA_W-1:0] CNT_VALUE,
  input  wire logic                       CNT_OVERFLOW,
  input  wire logic                       TRIG_EVENT,
  input  wire logic                       TRIGGER_IS_INTERNAL,
  input  wire logic                       SLAVE_TRIGGER_IN,
  // Sampling
  input  wire logic                       SAMPLE_BASE_TICK,
  // Pins
  input  wire logic                       CH1_PIN,
  input  wire logic                       CH2_PIN,
  // Channel results
  output logic                            CH1_OUT,
  output logic                            CH1_CAPTURE,
  output logic                            CH2_CAPTURE
);
  import tcm_pkg::*;

  localparam int NUM_CH = 2;

  logic [DATA_W-1:0] mode_ctrl;
  logic [DATA_W-1:0] cmp_shadow;
  logic [DATA_W-1:0] cmp_active;
  logic [1:0]        chan_on;
  logic [NUM_CH-1:0] prev_src;
  logic [DATA_W-1:0] cap_val [NUM_CH];

  // Register decode.
  wire wr_mode   = REG_WR && (REG_ADDR == ADDR_MODE_CTRL);
  wire wr_cmp    = REG_WR && (REG_ADDR == ADDR_CMP_VALUE);
  wire wr_chan   = REG_WR && (REG_ADDR == ADDR_CHAN_CTRL);

  // Output-mode view of channel 1 fields, plus the channel 2 direction.
  wire       preload  = mode_ctrl[PRELOAD_BIT];
  wire       fast_en  = mode_ctrl[FAST_BIT];
  wire [2:0] out_mode = mode_ctrl[OUT_MODE_LSB +: 3];
  wire [1:0] ch1_dir  = mode_ctrl[DIR_LSB +: 2];
  wire [1:0] ch2_dir  = mode_ctrl[CH_STRIDE + DIR_LSB +: 2];
  wire       pwm_mode = (out_mode == OUT_PWM_A) || (out_mode == OUT_PWM_B);
  wire       out_run  = chan_on[CH1_ON_BIT] && (ch1_dir == DIR_OUTPUT);
  wire       cmp_gt   = cmp_active > CNT_VALUE;
  wire       fast_hit = fast_en && pwm_mode && TRIG_EVENT;
  wire       pwm_raw  = (out_mode == OUT_PWM_A) ? cmp_gt : !cmp_gt;
  wire       fast_lvl = (out_mode == OUT_PWM_A);

  // Filtered pins, one per channel.
  logic [NUM_CH-1:0] filt;
  logic [NUM_CH-1:0] src;
  logic [NUM_CH-1:0] cap;
  wire  [NUM_CH-1:0] pins = {CH2_PIN, CH1_PIN};
  wire               trig_ok = SLAVE_TRIGGER_IN && TRIGGER_IS_INTERNAL;

  // Each channel uses the same filter and prescaler, so both are built by one loop.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    wire [1:0] dir      = mode_ctrl[CH_STRIDE*i + DIR_LSB +: 2];
    wire [3:0] filt_set = mode_ctrl[CH_STRIDE*i + FILTER_LSB +: 4];
    wire [1:0] pre_set  = mode_ctrl[CH_STRIDE*i + PRESCALE_LSB +: 2];
    wire       on       = chan_on[i];
    wire       edge_hit = src[i] && !prev_src[i] && on;

    tcm_input_filter u_filter (
      .clk         (SYS_CLK),
      .rst         (RST),
      .sample_tick (SAMPLE_BASE_TICK),
      .setting     (filt_set),
      .pin         (pins[i]),
      .filt        (filt[i])
    );

    // Own pin, the other channel's pin, or the slave trigger when it is internal.
    assign src[i] = (dir == DIR_OWN_PIN)   ? filt[i] :
                    (dir == DIR_OTHER_PIN) ? filt[NUM_CH-1-i] :
                    (dir == DIR_TRIGGER)   ? trig_ok : 1'b0;

    tcm_capture_prescale u_prescale (
      .clk      (SYS_CLK),
      .rst      (RST),
      .chan_on  (on),
      .prescale (pre_set),
      .edge_in  (edge_hit),
      .capture  (cap[i])
    );

    always_ff @(posedge SYS_CLK) begin
      if (RST) begin
        cap_val[i] <= CMP_RESET;
      end else if (edge_hit) begin
        cap_val[i] <= CNT_VALUE;
      end
    end
  end

  // Edge history of the routed capture sources.
  always_ff @(posedge SYS_CLK) begin
    if (RST) prev_src <= '0;
    else prev_src <= src;
  end

  // Configuration registers. Direction is expected to change only with the channel off.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mode_ctrl <= MODE_CTRL_RESET;
      chan_on   <= CHAN_CTRL_RESET;
    end else begin
      if (wr_mode) mode_ctrl <= REG_WDATA;
      if (wr_chan) chan_on <= REG_WDATA[1:0];
    end
  end

  // Compare value: a write with preload set waits for the overflow; otherwise it goes straight through.
  // A write in the overflow cycle lands in the shadow and is copied at the next overflow.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cmp_shadow <= CMP_RESET;
      cmp_active <= CMP_RESET;
    end else begin
      if (wr_cmp) cmp_shadow <= REG_WDATA;
      if (!preload && wr_cmp) cmp_active <= REG_WDATA;
      else if (preload && CNT_OVERFLOW) cmp_active <= cmp_shadow;
    end
  end

  // Channel 1 output. The fast path skips the compare and jumps to the level for counter below compare: 1 in PWM A, 0 in PWM B.
  always_ff @(posedge SYS_CLK) begin
    if (RST) CH1_OUT <= 1'b0;
    else if (!out_run || !pwm_mode) CH1_OUT <= 1'b0;
    else if (fast_hit) CH1_OUT <= fast_lvl;
    else CH1_OUT <= pwm_raw;
  end

  // Capture strobes.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CH1_CAPTURE <= 1'b0;
      CH2_CAPTURE <= 1'b0;
    end else begin
      CH1_CAPTURE <= cap[0];
      CH2_CAPTURE <= cap[1];
    end
  end

  // Read mux; unmapped addresses read as zero.
  wire [DATA_W-1:0] status = {12'h000, CH1_OUT, filt[1], filt[0], 1'b0};
  wire [DATA_W-1:0] rd_mux =
    (REG_ADDR == ADDR_MODE_CTRL)   ? mode_ctrl :
    (REG_ADDR == ADDR_CMP_VALUE)   ? cmp_shadow :
    (REG_ADDR == ADDR_CHAN_CTRL)   ? {14'h0000, chan_on} :
    (REG_ADDR == ADDR_STATUS)      ? status :
    (REG_ADDR == ADDR_CMP_ACTIVE)  ? cmp_active :
    (REG_ADDR == ADDR_CH1_CAPTURE) ? cap_val[0] :
    (REG_ADDR == ADDR_CH2_CAPTURE) ? cap_val[1] : 16'h0000;

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge SYS_CLK) begin
    if (RST) REG_RDATA <= 16'h0000;
    else REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
  end

  // Checks.
  property p_preload_copy;
    @(posedge SYS_CLK) disable iff (RST)
      (preload && CNT_OVERFLOW) |=> (cmp_active == $past(cmp_shadow));
  endproperty
  a_preload_copy: assert property (p_preload_copy) else $error("shadow not copied on overflow");

  property p_preload_hold;
    @(posedge SYS_CLK) disable iff (RST)
      (preload && !CNT_OVERFLOW) |=> $stable(cmp_active);
  endproperty
  a_preload_hold: assert property (p_preload_hold) else $error("active compare moved without overflow");

  property p_direct_write;
    @(posedge SYS_CLK) disable iff (RST)
      (!preload && wr_cmp) |=> (cmp_active == $past(REG_WDATA));
  endproperty
  a_direct_write: assert property (p_direct_write) else $error("direct compare write lost");

  property p_fast_output;
    @(posedge SYS_CLK) disable iff (RST)
      (out_run && fast_hit) |=> (CH1_OUT == $past(fast_lvl));
  endproperty
  a_fast_output: assert property (p_fast_output) else $error("fast output ignored trigger");

  property p_compare_output;
    @(posedge SYS_CLK) disable iff (RST)
      (out_run && pwm_mode && !fast_en) |=> (CH1_OUT == $past(pwm_raw));
  endproperty
  a_compare_output: assert property (p_compare_output) else $error("output not tied to compare");

  property p_ch1_trigger_gate;
    @(posedge SYS_CLK) disable iff (RST)
      (ch1_dir == DIR_TRIGGER && !TRIGGER_IS_INTERNAL) |-> !src[0];
  endproperty
  a_ch1_trigger_gate: assert property (p_ch1_trigger_gate) else $error("trigger used while not internal");

  property p_ch2_cross;
    @(posedge SYS_CLK) disable iff (RST)
      (ch2_dir == DIR_OTHER_PIN) |-> (src[1] == filt[0]);
  endproperty
  a_ch2_cross: assert property (p_ch2_cross) else $error("channel 2 not fed by channel 1 pin");

  property p_ch1_cross;
    @(posedge SYS_CLK) disable iff (RST)
      (ch1_dir == DIR_OTHER_PIN) |-> (src[0] == filt[1]);
  endproperty
  a_ch1_cross: assert property (p_ch1_cross) else $error("channel 1 not fed by channel 2 pin");

  property p_read_one_cycle;
    @(posedge SYS_CLK) disable iff (RST)
      !REG_RD |=> (REG_RDATA == 16'h0000);
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data outside its cycle");

endmodule : tcm_top

/* File: tb/tcm_partner.sv */
// Far-side model: counter value, events, trigger source, sample tick and channel pins.
`timescale 1ns/1ns
module tcm_partner (
  // Clock
  input  wire logic   clk,
  // Counter and trigger side
  output logic [15:0] cnt_value,
  output logic        cnt_overflow,
  output logic        trig_event,
  output logic        trig_internal,
  output logic        slave_trig,
  output logic        sample_tick,
  // Channel pins
  output logic        ch1_pin,
  output logic        ch2_pin
);
  initial begin
    {cnt_value, cnt_overflow, trig_event, trig_internal, slave_trig, ch1_pin, ch2_pin} = '0;
    // A full-rate tick keeps the filter sample grid on whole clocks, so glitch lengths are exact.
    sample_tick = 1'b1;
  end
  // Holds the selected sources (bit 0 pin 1, bit 1 pin 2, bit 2 slave trigger) at a level.
  task automatic drive(input logic [2:0] sel, input logic lvl, input int cycles);
    @(posedge clk);
    if (sel[0]) ch1_pin <= lvl;
    if (sel[1]) ch2_pin <= lvl;
    if (sel[2]) slave_trig <= lvl;
    repeat (cycles - 1) @(posedge clk);
  endtask : drive
  // One-cycle event: 0 for counter overflow, 1 for trigger.
  task automatic pulse(input logic trig);
    @(posedge clk);
    if (trig) trig_event <= 1'b1;
    else cnt_overflow <= 1'b1;
    @(posedge clk);
    trig_event <= 1'b0;
    cnt_overflow <= 1'b0;
  endtask : pulse
  task automatic levels(input logic [15:0] cnt, input logic internal);
    @(posedge clk);
    cnt_value <= cnt;
    trig_internal <= internal;
  endtask : levels
endmodule : tcm_partner

/* File: tb/tb_tcm_top.sv */
// Self-checking bench for the timer channel mode block.
`timescale 1ns/1ns
module tb_tcm_top;
  import tcm_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_seen = 1'b0;
  logic [15:0] reg_rdata, cnt_value, exp_v, r;
  logic        cnt_overflow, trig_event, trig_internal, slave_trig, sample_tick;
  logic        ch1_pin, ch2_pin, ch1_out, ch1_capture, ch2_capture;
  logic [15:0] exp_q[$];
  int          bad_count = 0, samples_checked = 0, caps1 = 0, caps2 = 0, b1, b2, per;
  int          fn[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
  int          fdiv[16] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 4, 5, 5, 5};
  logic [15:0] omode[4] = '{16'h0064, 16'h0060, 16'h0014, 16'h0074};
  logic        oidle[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic        oexp[4] = '{1'b1, 1'b0, 1'b0, 1'b0};

  tcm_top dut (.SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CNT_VALUE(cnt_value), .CNT_OVERFLOW(cnt_overflow),
    .TRIG_EVENT(trig_event), .TRIGGER_IS_INTERNAL(trig_internal), .SLAVE_TRIGGER_IN(slave_trig),
    .SAMPLE_BASE_TICK(sample_tick), .CH1_PIN(ch1_pin), .CH2_PIN(ch2_pin), .CH1_OUT(ch1_out),
    .CH1_CAPTURE(ch1_capture), .CH2_CAPTURE(ch2_capture));
  tcm_partner p (.clk(sys_clk), .cnt_value(cnt_value), .cnt_overflow(cnt_overflow), .trig_event(trig_event),
    .trig_internal(trig_internal), .slave_trig(slave_trig), .sample_tick(sample_tick), .ch1_pin(ch1_pin),
    .ch2_pin(ch2_pin));

  always #4 sys_clk = ~sys_clk;

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_count(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h captures", $time, got, exp);
    end
  endtask : cmp_count
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // The expected word is queued here and checked by the watcher when the read data stand.
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd
  // Channels are switched off around every mode write so direction fields only change while off.
  task automatic cfg(input logic [15:0] mode);
    wr(ADDR_CHAN_CTRL, 16'h0000);
    wr(ADDR_MODE_CTRL, mode);
    wr(ADDR_CHAN_CTRL, 16'h0003);
    b1 = caps1;
    b2 = caps2;
  endtask : cfg
  task automatic edges(input logic [2:0] src, input int n);
    repeat (n) begin
      p.drive(src, 1'b1, 2);
      p.drive(src, 1'b0, 2);
    end
  endtask : edges
  task automatic chk(input int e1, input int e2);
    repeat (6) @(posedge sys_clk);
    cmp_count(caps1 - b1, e1);
    cmp_count(caps2 - b2, e2);
  endtask : chk
  task automatic out_chk(input logic e);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp_val({15'h0000, ch1_out}, {15'h0000, e});
  endtask : out_chk

  always @(posedge sys_clk) begin
    rd_seen <= reg_rd;
    if (ch1_capture === 1'b1) caps1++;
    if (ch2_capture === 1'b1) caps2++;
  end
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
      cmp_val(reg_rdata, exp_v);
    end
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(80394));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ADDR_MODE_CTRL, MODE_CTRL_RESET);
    rd(ADDR_CMP_VALUE, CMP_RESET);
    rd(ADDR_CHAN_CTRL, {14'h0000, CHAN_CTRL_RESET});
    rd(8'hfc, 16'h0000);
    r = 16'($urandom());
    wr(ADDR_MODE_CTRL, r);
    rd(ADDR_MODE_CTRL, r);
    wr(ADDR_MODE_CTRL, 16'h0000);
    r = 16'($urandom());
    wr(ADDR_CMP_VALUE, r);
    rd(ADDR_CMP_ACTIVE, r);
    wr(ADDR_MODE_CTRL, 16'h0008);
    wr(ADDR_CMP_VALUE, ~r);
    rd(ADDR_CMP_ACTIVE, r);
    p.pulse(1'b0);
    rd(ADDR_CMP_ACTIVE, ~r);
    wr(ADDR_MODE_CTRL, 16'h0060);
    wr(ADDR_CMP_VALUE, 16'h0080);
    wr(ADDR_CHAN_CTRL, 16'h0001);
    p.levels(16'h0010, 1'b0);
    out_chk(1'b1);
    p.levels(16'h0100, 1'b0);
    out_chk(1'b0);
    for (int i = 0; i < 4; i++) begin
      cfg(omode[i]);
      out_chk(oidle[i]);
      p.pulse(1'b1);
      @(negedge sys_clk);
      cmp_val({15'h0000, ch1_out}, {15'h0000, oexp[i]});
    end
    for (int ps = 0; ps < 4; ps++) begin
      cfg({4'h0, ps[1:0], 2'h1, 4'h0, ps[1:0], 2'h1});
      edges(3'b011, 8);
      chk(8 >> ps, 8 >> ps);
    end
    for (int k = 0; k < 2; k++) begin
      cfg(16'h0005);
      edges(3'b001, 1);
      chk(0, 0);
    end
    cfg(16'h0101);
    edges(3'b001, 1);
    chk(1, 0);
    cfg(16'h0202);
    edges(3'b001, 1);
    chk(0, 1);
    edges(3'b010, 1);
    chk(1, 1);
    for (int t = 1; t >= 0; t--) begin
      p.levels(16'h0100, t[0]);
      cfg(16'h0303);
      edges(3'b100, 1);
      chk(t, t);
    end
    for (int f = 0; f < 16; f++) begin
      per = 1 << fdiv[f];
      cfg({f[3:0], 4'h1, f[3:0], 4'h1});
      if (fn[f] > 1) p.drive(3'b011, 1'b1, (fn[f] - 1) * per);
      p.drive(3'b011, 1'b0, (fn[f] + 1) * per + 2);
      p.drive(3'b011, 1'b1, (fn[f] + 1) * per + 2);
      p.drive(3'b011, 1'b0, (fn[f] + 1) * per + 2);
      chk(1, 1);
    end
    end_of_test();
  end
endmodule : tb_tcm_top
